// >>> pkg/timer_pkg.sv
package timer_pkg;
   // ==========================================================
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CNT0 = 8'h40;
   localparam logic [7:0] IDX_CNT1 = 8'h41;
   localparam logic [7:0] IDX_CNT2 = 8'h42;
   localparam logic [7:0] IDX_CTL012 = 8'h43;
   localparam logic [7:0] IDX_CNT3 = 8'h44;
   localparam logic [7:0] IDX_CTL3 = 8'h47;
   // ==========================================================
   // Control word fields
   localparam int CW_SC_LO = 6;
   localparam int CW_RW_LO = 4;
   localparam int CW_MODE_LO = 1;
   localparam int CW_BCD = 0;
   localparam int RB_NO_COUNT = 5;
   localparam int RB_NO_STATUS = 4;
   localparam int RB_SEL_LO = 1;
   localparam logic [1:0] SC_READBACK = 2'h3;
   localparam logic [1:0] RW_LATCH = 2'h0;
   localparam logic [1:0] RW_LSB = 2'h1;
   localparam logic [1:0] RW_MSB = 2'h2;
   localparam logic [1:0] RW_BOTH = 2'h3;
   localparam logic [2:0] MODE_TC = 3'h0;
   // ==========================================================
   // Reset values
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;
endpackage

// >>> logic/interval_timer_program_readback.sv
`timescale 1ns/1ns
// Summary of operation
// R1: Each timer has one byte count register; LSB, MSB, or LSB then MSB.
// R2: Two control registers: one for timers 0-2, one for timer 3.
// R3: Regular control word picks timer, mode, BCD and byte access order.
// R4: Host writes control word before the initial count, in its format.
// R5: Writing a new count never changes the programmed mode.
// R6: Control write resets timer control logic at once and sets output.
// R7: Host keeps other routines off a timer between two count bytes.
// R8: Unlatched direct reads are only reliable with the timer clock stopped.
// R9: Only timers 2 and 3 have gates; timers 0 and 1 always enabled.
// R10: Latch command decoded from two bits, two more pick the counter.
// R11: Latch freezes count until read or reprogram, then tracks again.
// R12: Latch keeps mode and counting; several counters may be latched.
// R13: Second latch before the first is read is ignored.
// R14: Latched count read in programmed format; other timers may interleave.
// R15: Separate read and write byte pointers per timer.
// R16: Host keeps other routines off a timer between two read bytes.
// R17: Read-back may latch several timers; each unlatches when read.
// R18: Repeated read-back count latches before reading are ignored.
// R19: Read-back status latches mode and output level per timer.
// R20: Host must program every timer after reset before use.
// R21: With both latched, status reads first, then count, then live.
// R22: Status null flag shows count not yet moved into counting element.
// R23: Repeated status latches before reading are ignored.
// R24: Per-direction byte pointers toggle per access; control write clears.
// R25: Control write drops latched status and count.
module interval_timer_program_readback #(
   parameter int ADR_W = 10
) (
   input wire logic mclk_in, // System clock
   input wire logic nrst_in, // Async reset, active low
   input wire logic wb_cyc_in, // Bus cycle
   input wire logic wb_stb_in, // Strobe
   input wire logic wb_we_in, // Write enable
   input wire logic [ADR_W-1:0] wb_adr_in, // Byte address
   input wire logic [3:0] wb_sel_in, // Byte lanes
   input wire logic [31:0] wb_dat_in, // Write data
   output logic [31:0] wb_dat_out, // Read data
   output logic wb_ack_out, // Acknowledge
   input wire logic shared_timer_clock_in, // Shared timer clock pin
   input wire logic gate2_in, // Timer 2 gate pin
   input wire logic gate3_in, // Timer 3 gate pin
   output logic [3:0] timer_output_pin_out // Timer outputs
);
   // ==========================================================
   // Helpers
   function automatic logic [15:0] count_down(input logic [15:0] v, input logic bcd);
      logic [15:0] r;
      logic borrow;
      r = v;
      borrow = 1'b1;
      if (!bcd) begin
         r = v - 16'h0001;
      end else begin
         for (int k = 0; k < 4; k++) begin
            if (borrow) begin
               if (r[k*4 +: 4] == 4'h0) begin
                  r[k*4 +: 4] = 4'h9;
               end else begin
                  r[k*4 +: 4] = r[k*4 +: 4] - 4'h1;
                  borrow = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction

   // ==========================================================
   // State
   logic ack_q;
   logic [31:0] rdata_q;
   logic [3:0][2:0] mode_q;
   logic [3:0] bcd_q;
   logic [3:0][1:0] rw_q;
   logic [3:0] wr_ptr_q;
   logic [3:0] rd_ptr_q;
   logic [3:0][15:0] load_q; // count_load_register
   logic [3:0][15:0] ce_q;
   logic [3:0][15:0] hold_q; // count_hold_latch
   logic [3:0] hold_lat_q;
   logic [3:0][7:0] stat_q;
   logic [3:0] stat_lat_q;
   logic [3:0] pend_q;
   logic [3:0] null_q;
   logic [3:0] out_q;
   logic tclk_s1, tclk_s2, tclk_s3;
   logic [1:0] gate_s1, gate_s2;

   // ==========================================================
   // Decode
   logic req, wr, rd, tick;
   logic [7:0] idx, din, rbyte;
   logic [3:0] cnt_hit, prog, latch_c, latch_s, cw, cr, wr_done, rd_last, gate_v;
   logic [2:0] new_mode;

   assign req = wb_cyc_in && wb_stb_in && !ack_q;
   assign wr = req && wb_we_in && wb_sel_in[0];
   assign rd = req && !wb_we_in;
   assign idx = wb_adr_in[9:2];
   assign din = wb_dat_in[7:0];
   assign new_mode = din[timer_pkg::CW_MODE_LO +: 3];
   assign tick = tclk_s2 && !tclk_s3;
   // Timers 0 and 1 have no gate pin and always count
   assign gate_v = {gate_s2, 2'b11}; // R9

   // Command decode for both control registers
   always_comb begin
      logic [1:0] sc;
      sc = din[timer_pkg::CW_SC_LO +: 2];
      cnt_hit = {idx == timer_pkg::IDX_CNT3, idx == timer_pkg::IDX_CNT2,
                 idx == timer_pkg::IDX_CNT1, idx == timer_pkg::IDX_CNT0};
      prog = 4'h0;
      latch_c = 4'h0;
      latch_s = 4'h0;
      if (wr && idx == timer_pkg::IDX_CTL012) begin // R2
         if (sc == timer_pkg::SC_READBACK) begin
            for (int i = 0; i < 3; i++) begin // R17
               latch_c[i] = din[timer_pkg::RB_SEL_LO + i] && !din[timer_pkg::RB_NO_COUNT];
               latch_s[i] = din[timer_pkg::RB_SEL_LO + i] && !din[timer_pkg::RB_NO_STATUS]; // R19
            end
         end else if (din[timer_pkg::CW_RW_LO +: 2] == timer_pkg::RW_LATCH) begin
            latch_c[sc] = 1'b1; // R10
         end else begin
            prog[sc] = 1'b1; // R3
         end
      end
      // Timer 3 has its own control word; select field only flags read-back
      if (wr && idx == timer_pkg::IDX_CTL3) begin // R2
         if (sc == timer_pkg::SC_READBACK) begin
            latch_c[3] = din[timer_pkg::RB_SEL_LO] && !din[timer_pkg::RB_NO_COUNT];
            latch_s[3] = din[timer_pkg::RB_SEL_LO] && !din[timer_pkg::RB_NO_STATUS];
         end else if (din[timer_pkg::CW_RW_LO +: 2] == timer_pkg::RW_LATCH) begin
            latch_c[3] = 1'b1; // R10
         end else begin
            prog[3] = 1'b1;
         end
      end
      for (int i = 0; i < 4; i++) begin
         cw[i] = wr && cnt_hit[i];
         cr[i] = rd && cnt_hit[i];
         wr_done[i] = cw[i] && (rw_q[i] != timer_pkg::RW_BOTH || wr_ptr_q[i]); // R1
         rd_last[i] = cr[i] && !stat_lat_q[i] && (rw_q[i] != timer_pkg::RW_BOTH || rd_ptr_q[i]); // R14
      end
   end

   // Read byte: status first, then latched or live count
   always_comb begin
      logic [15:0] val;
      val = timer_pkg::COUNT_RST;
      rbyte = 8'h00;
      for (int i = 0; i < 4; i++) begin
         if (cnt_hit[i]) begin
            val = hold_lat_q[i] ? hold_q[i] : ce_q[i]; // R11
            if (stat_lat_q[i]) begin
               rbyte = stat_q[i]; // R21
            end else if (rw_q[i] == timer_pkg::RW_MSB) begin
               rbyte = val[15:8];
            end else if (rw_q[i] == timer_pkg::RW_BOTH && rd_ptr_q[i]) begin
               rbyte = val[15:8];
            end else begin
               rbyte = val[7:0];
            end
         end
      end
   end

   // ==========================================================
   // Bus slave: one wait state, unmapped reads return zero
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ack_q <= 1'b0;
         rdata_q <= timer_pkg::RDATA_RST;
      end else begin
         ack_q <= req;
         if (rd) begin
            rdata_q <= {24'h00_0000, rbyte};
         end
      end
   end
   assign wb_ack_out = ack_q;
   assign wb_dat_out = rdata_q;

   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         {tclk_s1, tclk_s2, tclk_s3} <= 3'b000;
         gate_s1 <= 2'b00;
         gate_s2 <= 2'b00;
      end else begin
         tclk_s1 <= shared_timer_clock_in;
         tclk_s2 <= tclk_s1;
         tclk_s3 <= tclk_s2;
         gate_s1 <= {gate3_in, gate2_in};
         gate_s2 <= gate_s1;
      end
   end

   // ==========================================================
   // Programmed configuration, touched only by control words
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mode_q <= '0;
         bcd_q <= 4'h0;
         rw_q <= '0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (prog[i]) begin // R3
               mode_q[i] <= new_mode;
               bcd_q[i] <= din[timer_pkg::CW_BCD];
               rw_q[i] <= din[timer_pkg::CW_RW_LO +: 2];
            end
         end
      end
   end

   // Independent write and read byte pointers
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wr_ptr_q <= 4'h0;
         rd_ptr_q <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (prog[i]) begin
               wr_ptr_q[i] <= 1'b0; // R24
               rd_ptr_q[i] <= 1'b0;
            end else begin
               if (cw[i] && rw_q[i] == timer_pkg::RW_BOTH) begin
                  wr_ptr_q[i] <= !wr_ptr_q[i]; // R15
               end
               if (cr[i] && !stat_lat_q[i] && rw_q[i] == timer_pkg::RW_BOTH) begin
                  rd_ptr_q[i] <= !rd_ptr_q[i]; // R24
               end
            end
         end
      end
   end

   // Load register; a single byte clears the other half
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         load_q <= '0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (cw[i]) begin // R1
               case (rw_q[i])
                  timer_pkg::RW_LSB: load_q[i] <= {8'h00, din};
                  timer_pkg::RW_MSB: load_q[i] <= {din, 8'h00};
                  timer_pkg::RW_BOTH: begin
                     if (wr_ptr_q[i]) begin
                        load_q[i][15:8] <= din;
                     end else begin
                        load_q[i][7:0] <= din;
                     end
                  end
                  default: load_q[i] <= load_q[i];
               endcase
            end
         end
      end
   end

   // Count hold latch; first capture wins until read or reprogram
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         hold_q <= '0;
         hold_lat_q <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (prog[i]) begin
               hold_lat_q[i] <= 1'b0; // R25
            end else if (latch_c[i] && !hold_lat_q[i]) begin
               hold_q[i] <= ce_q[i]; // R11
               hold_lat_q[i] <= 1'b1; // R13 R18
            end else if (rd_last[i]) begin
               hold_lat_q[i] <= 1'b0; // R17
            end
         end
      end
   end

   // Status latch; read once, then count bytes follow
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         stat_q <= '0;
         stat_lat_q <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (prog[i]) begin
               stat_lat_q[i] <= 1'b0; // R25
            end else if (latch_s[i] && !stat_lat_q[i]) begin
               stat_q[i] <= {out_q[i], null_q[i], rw_q[i], mode_q[i], bcd_q[i]}; // R19 R23
               stat_lat_q[i] <= 1'b1;
            end else if (cr[i]) begin
               stat_lat_q[i] <= 1'b0; // R21
            end
         end
      end
   end

   // ==========================================================
   // Counting element; mode is never touched here
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ce_q <= '0;
         pend_q <= 4'h0;
         null_q <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (tick && pend_q[i]) begin
               ce_q[i] <= load_q[i];
               pend_q[i] <= 1'b0;
               null_q[i] <= 1'b0; // R22
            end else if (tick && gate_v[i]) begin
               ce_q[i] <= count_down(ce_q[i], bcd_q[i]); // R12
            end
            // Reprogram cancels a pending load; a new count wins over transfer
            if (prog[i]) begin
               pend_q[i] <= 1'b0; // R6
               null_q[i] <= 1'b1;
            end else if (wr_done[i]) begin
               pend_q[i] <= 1'b1; // R5
               null_q[i] <= 1'b1; // R22
            end
         end
      end
   end

   // Output pins; control write forces the known level at once
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         out_q <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (prog[i]) begin
               out_q[i] <= (new_mode != timer_pkg::MODE_TC); // R6
            end else if (tick && !pend_q[i] && gate_v[i]) begin
               if (mode_q[i] == timer_pkg::MODE_TC) begin
                  out_q[i] <= out_q[i] || (ce_q[i] == 16'h0001);
               end else begin
                  out_q[i] <= (ce_q[i] != 16'h0002);
               end
            end
         end
      end
   end
   assign timer_output_pin_out = out_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!nrst_in);

   a_mode_kept_on_count: assert property (|cw |=> mode_q == $past(mode_q)) // R5
      else $error("mode changed by count write");
   a_prog_clears_state: assert property (prog[0] |=> !hold_lat_q[0] && !stat_lat_q[0]
      && !wr_ptr_q[0] && !rd_ptr_q[0] && null_q[0]) // R6
      else $error("control word left state behind");
   a_latch_captures: assert property (latch_c[2] && !hold_lat_q[2] && !prog[2]
      |=> hold_lat_q[2] && hold_q[2] == $past(ce_q[2])) // R11
      else $error("latch did not capture count");
   a_latch_first_kept: assert property (hold_lat_q[1] && !rd_last[1] && !prog[1]
      |=> hold_lat_q[1] && $stable(hold_q[1])) // R13
      else $error("held count disturbed");
   a_gate_tied_runs: assert property (tick && !pend_q[0] && !prog[0]
      |=> ce_q[0] != $past(ce_q[0])) // R9
      else $error("ungated timer did not count");
   a_status_first_read: assert property (cr[3] && stat_lat_q[3] |=> !stat_lat_q[3]
      && wb_dat_out[7:0] == $past(stat_q[3]) ##1 !wb_ack_out) // R21
      else $error("status not returned first");
   a_null_set_on_load: assert property (wr_done[0] |=> null_q[0] && pend_q[0]) // R22
      else $error("null flag not set");
   a_transfer_clears: assert property (tick && pend_q[1] && !wr_done[1] && !prog[1]
      |=> !null_q[1] && ce_q[1] == $past(load_q[1])) // R22
      else $error("count not transferred");
   a_lsb_only_write: assert property (cw[1] && rw_q[1] == timer_pkg::RW_LSB
      |=> load_q[1] == {8'h00, $past(din)}) // R1
      else $error("lsb write wrong");
   a_read_ptr_apart: assert property (cw[0] |=> rd_ptr_q[0] == $past(rd_ptr_q[0])) // R15
      else $error("write moved read pointer");
   a_others_stay: assert property (rd_last[3] && hold_lat_q[0] && !latch_c[0]
      |=> hold_lat_q[0]) // R17
      else $error("other timer unlatched");
   a_status_first_kept: assert property (stat_lat_q[2] && latch_s[2] |=> $stable(stat_q[2])) // R23
      else $error("status recaptured");
   c_latch_read: cover property (latch_c[0] ##[1:40] rd_last[0]);
   c_readback_both: cover property (latch_c[0] && latch_s[0]);
   c_two_byte_write: cover property (cw[2] && rw_q[2] == timer_pkg::RW_BOTH && wr_ptr_q[2]);
endmodule // interval_timer_program_readback

// >>> bench/timer_host_model.sv
`timescale 1ns/1ns
// ==========================================================
// Host processor: classic Wishbone master, one transfer at a time
module timer_host_model (
   input wire logic mclk_in, // System clock
   output logic cyc_out, // Bus cycle
   output logic stb_out, // Strobe
   output logic we_out, // Write enable
   output logic [3:0] sel_out, // Byte lanes
   input wire logic [3:0] lanes_in, // Lanes for the next transfer
   output logic [9:0] adr_out, // Byte address
   output logic [31:0] dat_out, // Write data
   input wire logic [31:0] dat_in, // Read data
   input wire logic ack_in // Acknowledge
);
   // Idle bus from time zero
   initial begin
      cyc_out = 1'b0;
      stb_out = 1'b0;
      we_out = 1'b0;
      sel_out = 4'h0;
      adr_out = 10'h000;
      dat_out = 32'h0000_0000;
   end

   // ==========================================================
   // Bus cycle
   // Request held until ack is sampled; only the bench watchdog ends a hang
   task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd);
      @(posedge mclk_in);
      cyc_out <= 1'b1;
      stb_out <= 1'b1;
      we_out <= we;
      sel_out <= lanes_in;
      adr_out <= {idx, 2'b00};
      dat_out <= {24'h00_0000, wd};
      do begin
         @(posedge mclk_in);
      end while (ack_in !== 1'b1);
      rd = dat_in;
      cyc_out <= 1'b0;
      stb_out <= 1'b0;
   endtask

   // ==========================================================
   // Count transfers
   // Bytes follow the programmed format, low first, never split by others
   task automatic cnt_wr(input logic [7:0] idx, input logic [1:0] fmt, input logic [15:0] v);
      logic [31:0] d;
      if (fmt != timer_pkg::RW_MSB) begin
         xfer(1'b1, idx, v[7:0], d);
      end
      if (fmt != timer_pkg::RW_LSB) begin
         xfer(1'b1, idx, v[15:8], d);
      end
   endtask

   // Both bytes of a two-byte read taken by one caller, back to back
   task automatic cnt_rd(input logic [7:0] idx, input logic [1:0] fmt, output logic [15:0] v);
      logic [31:0] d;
      v = 16'h0000;
      if (fmt != timer_pkg::RW_MSB) begin
         xfer(1'b0, idx, 8'h00, d);
         v[7:0] = d[7:0];
      end
      if (fmt != timer_pkg::RW_LSB) begin
         xfer(1'b0, idx, 8'h00, d);
         v[15:8] = d[7:0];
      end
   endtask
endmodule // timer_host_model

// >>> bench/interval_timer_program_readback_bench.sv
`timescale 1ns/1ns
// ==========================================================
// Self-checking bench for timer programming and count read-out
module interval_timer_program_readback_bench;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic tclk = 1'b0;
   logic g2 = 1'b1;
   logic g3 = 1'b1;
   logic cyc, stb, we, ack;
   logic [3:0] sel;
   logic [3:0] lanes = 4'hf;
   logic [9:0] adr;
   logic [31:0] wdat, rdat, d;
   logic [3:0] timer_output_pin;
   logic [15:0] v, n0, n1, n2, n3;
   logic [1:0] f;
   int err_total = 0;
   int n_tests = 0;
   int m;

   // Free-running system clock
   initial begin
      forever #5 clk = ~clk;
   end

   interval_timer_program_readback interval_timer_program_readback_inst (.mclk_in(clk), .nrst_in(nrst),
      .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
      .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .shared_timer_clock_in(tclk),
      .gate2_in(g2), .gate3_in(g3), .timer_output_pin_out(timer_output_pin));
   timer_host_model timer_host_model_inst (.mclk_in(clk), .cyc_out(cyc), .stb_out(stb), .we_out(we),
      .sel_out(sel), .lanes_in(lanes),
      .adr_out(adr), .dat_out(wdat), .dat_in(rdat), .ack_in(ack));

   // ==========================================================
   // Helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Timer clock pulse, then room for the synchroniser and output update
   task automatic tick(input int k);
      repeat (k) begin
         @(posedge clk);
         tclk <= 1'b1;
         repeat (4) @(posedge clk);
         tclk <= 1'b0;
         repeat (8) @(posedge clk);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] x);
      timer_host_model_inst.xfer(1'b1, idx, x, d);
   endtask
   task automatic rd(input logic [7:0] idx);
      timer_host_model_inst.xfer(1'b0, idx, 8'h00, d);
   endtask
   task automatic crd(input logic [7:0] idx);
      timer_host_model_inst.cnt_rd(idx, timer_pkg::RW_BOTH, v);
   endtask
   function automatic logic [31:0] stat(input logic o, input logic nul, input logic [1:0] fm, input logic [3:0] mb);
      return {24'h00_0000, o, nul, fm, mb};
   endfunction
   // Byte values kept well above zero so no count wraps during the run
   function automatic logic [15:0] rnd16();
      return {8'h10 + 8'($urandom % 240), 8'h10 + 8'($urandom % 240)};
   endfunction
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected few hundred cycles
   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      test_done();
   end

   // ==========================================================
   // Scenarios
   initial begin
      void'($urandom(32'hd259_20fa));
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      rd(8'h45);
      check(d, 32'h0);
      // Timer 0, mode 0, two bytes: output low, count not yet loaded
      n0 = rnd16();
      wr(timer_pkg::IDX_CTL012, 8'h30);
      repeat (2) @(posedge clk);
      check(32'(timer_output_pin[0]), 32'h0);
      timer_host_model_inst.cnt_wr(timer_pkg::IDX_CNT0, timer_pkg::RW_BOTH, n0);
      wr(timer_pkg::IDX_CTL012, 8'he2);
      rd(timer_pkg::IDX_CNT0);
      check(d, stat(1'b0, 1'b1, timer_pkg::RW_BOTH, 4'h0));
      // Latch, count on, latch again; reads and writes interleaved
      tick(1);
      wr(timer_pkg::IDX_CTL012, 8'h00);
      tick(2);
      wr(timer_pkg::IDX_CTL012, 8'h00);
      v = rnd16();
      n1 = v;
      rd(timer_pkg::IDX_CNT0);
      check(d, 32'(n0[7:0]));
      wr(timer_pkg::IDX_CNT0, v[7:0]);
      rd(timer_pkg::IDX_CNT0);
      check(d, 32'(n0[15:8]));
      wr(timer_pkg::IDX_CNT0, n1[15:8]);
      wr(timer_pkg::IDX_CTL012, 8'he2);
      rd(timer_pkg::IDX_CNT0);
      check(d, stat(1'b0, 1'b1, timer_pkg::RW_BOTH, 4'h0));
      // Status and count together: status first, then count, then live
      tick(1);
      wr(timer_pkg::IDX_CTL012, 8'hc2);
      rd(timer_pkg::IDX_CNT0);
      check(d, stat(1'b0, 1'b0, timer_pkg::RW_BOTH, 4'h0));
      crd(timer_pkg::IDX_CNT0);
      check(32'(v), 32'(n1));
      crd(timer_pkg::IDX_CNT0);
      check(32'(v), 32'(n1));
      n0 = n1;
      // Timers 1 to 3 loaded, gates 2 and 3 closed, several latched at once
      n1 = rnd16();
      n2 = rnd16();
      n3 = rnd16();
      wr(timer_pkg::IDX_CTL012, 8'h70);
      wr(timer_pkg::IDX_CTL012, 8'hb0);
      wr(timer_pkg::IDX_CTL3, 8'h30);
      timer_host_model_inst.cnt_wr(timer_pkg::IDX_CNT1, timer_pkg::RW_BOTH, n1);
      timer_host_model_inst.cnt_wr(timer_pkg::IDX_CNT2, timer_pkg::RW_BOTH, n2);
      timer_host_model_inst.cnt_wr(timer_pkg::IDX_CNT3, timer_pkg::RW_BOTH, n3);
      tick(1);
      g2 <= 1'b0;
      g3 <= 1'b0;
      tick(3);
      wr(timer_pkg::IDX_CTL012, 8'hde);
      wr(timer_pkg::IDX_CTL3, 8'hd2);
      tick(2);
      wr(timer_pkg::IDX_CTL012, 8'hde);
      wr(timer_pkg::IDX_CTL3, 8'hd2);
      crd(timer_pkg::IDX_CNT3);
      check(32'(v), 32'(n3));
      crd(timer_pkg::IDX_CNT2);
      check(32'(v), 32'(n2));
      crd(timer_pkg::IDX_CNT1);
      check(32'(v), 32'(n1 - 16'h0003));
      crd(timer_pkg::IDX_CNT0);
      check(32'(v), 32'(n0 - 16'h0004));
      crd(timer_pkg::IDX_CNT1);
      check(32'(v), 32'(n1 - 16'h0005));
      // Timer 3 status, then a plain latch command through its own control word
      wr(timer_pkg::IDX_CTL3, 8'he2);
      wr(timer_pkg::IDX_CTL3, 8'h00);
      rd(timer_pkg::IDX_CNT3);
      check(d, stat(1'b0, 1'b0, timer_pkg::RW_BOTH, 4'h0));
      crd(timer_pkg::IDX_CNT3);
      check(32'(v), 32'(n3));
      // Reprogram in mid-read and mid-write: latch and pointers dropped
      g2 <= 1'b1;
      wr(timer_pkg::IDX_CTL012, 8'h80);
      rd(timer_pkg::IDX_CNT2);
      wr(timer_pkg::IDX_CTL012, 8'hb0);
      wr(timer_pkg::IDX_CNT2, 8'h5a);
      wr(timer_pkg::IDX_CTL012, 8'hb0);
      n2 = rnd16();
      timer_host_model_inst.cnt_wr(timer_pkg::IDX_CNT2, timer_pkg::RW_BOTH, n2);
      // Status taken while the load waits; a second status latch is ignored
      wr(timer_pkg::IDX_CTL012, 8'he8);
      tick(1);
      wr(timer_pkg::IDX_CTL012, 8'he8);
      rd(timer_pkg::IDX_CNT2);
      check(d, stat(1'b0, 1'b1, timer_pkg::RW_BOTH, 4'h0));
      crd(timer_pkg::IDX_CNT2);
      check(32'(v), 32'(n2));
      // Every mode, format and count code on timer 1
      for (m = 0; m < 6; m++) begin
         f = 2'(m % 3 + 1);
         wr(timer_pkg::IDX_CTL012, {2'b01, f, 3'(m), 1'(m % 2)});
         repeat (2) @(posedge clk);
         check(32'(timer_output_pin[1]), 32'(m != 0));
         timer_host_model_inst.cnt_wr(timer_pkg::IDX_CNT1, f, rnd16());
         wr(timer_pkg::IDX_CTL012, 8'he4);
         rd(timer_pkg::IDX_CNT1);
         check(d, stat(m != 0, 1'b1, f, {3'(m), 1'(m % 2)}));
         tick(1);
         wr(timer_pkg::IDX_CTL012, 8'he4);
         rd(timer_pkg::IDX_CNT1);
         check(d, stat(m != 0, 1'b0, f, {3'(m), 1'(m % 2)}));
      end
      // Write with lane 0 off is ignored, so timer 1 keeps its high output
      lanes <= 4'he;
      wr(timer_pkg::IDX_CTL012, 8'h70);
      lanes <= 4'hf;
      repeat (2) @(posedge clk);
      check(32'(timer_output_pin), 32'h2);
      test_done();
   end
endmodule // interval_timer_program_readback_bench
